// ==== rtl/crcbr_pkg.sv ====
// crcbr_pkg: constants for the checksum unit with bit reverse port
// assumes an 8-bit special function register bus with 8-bit addresses
package crcbr_pkg;
  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_CONTROL = 8'h84;
  localparam logic [7:0] ADDR_BYTE_INPUT = 8'h85;
  localparam logic [7:0] ADDR_RESULT_PORT = 8'h86;
  localparam logic [7:0] ADDR_BIT_REVERSE = 8'h87;
  // control field positions
  localparam int CTL_POLY_SELECT = 4;
  localparam int CTL_INIT_STROBE = 3;
  localparam int CTL_INIT_VALUE = 2;
  localparam int CTL_PTR_HI = 1;
  localparam int CTL_PTR_LO = 0;
  // generators and presets
  localparam logic [15:0] POLY16 = 16'h1021;
  localparam logic [31:0] POLY32 = 32'h04C11DB7;
  localparam logic [31:0] POLY32_REFLECTED = 32'hEDB88320;
  localparam logic [31:0] PRESET_ZERO = 32'h00000000;
  localparam logic [31:0] PRESET_ONES = 32'hFFFFFFFF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] PTR_STEP = 2'h1;
  localparam int BITS_PER_BYTE = 8;
endpackage

// ==== rtl/crcbr_fold.sv ====
// crcbr_fold: folds one byte into a running checksum, purely combinational
// assumes the caller registers the result
`timescale 1ns/1ps
module crcbr_fold
  import crcbr_pkg::*;
(
  input wire logic [31:0] acc_in,
  input wire logic [7:0] data_in,
  input wire logic poly16_mode,
  output logic [31:0] acc_out
);
  logic [31:0] a32;
  logic [15:0] a16;

  always_comb
  begin
    // 16-bit path: msb first; 32-bit path: reflected, lsb first
    a16 = acc_in[15:0] ^ {data_in, BYTE_ZERO}; // RULE_13
    a32 = acc_in ^ {24'h000000, data_in}; // RULE_14
    for (int i = 0; i < BITS_PER_BYTE; i++)
    begin
      a16 = a16[15] ? ((a16 << 1) ^ POLY16) : (a16 << 1); // RULE_13
      a32 = a32[0] ? ((a32 >> 1) ^ POLY32_REFLECTED) : (a32 >> 1); // RULE_14
    end
    // upper half is dropped in 16-bit mode, the result is 16 bits wide
    acc_out = poly16_mode ? {16'h0000, a16} : a32; // RULE_01 RULE_05
  end
endmodule // crcbr_fold

// ==== rtl/crcbr_flip.sv ====
// crcbr_flip: mirrors the bit order of a byte
// assumes nothing of its surroundings; combinational
`timescale 1ns/1ps
module crcbr_flip
(
  input wire logic [7:0] byte_in,
  output logic [7:0] byte_out
);
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      byte_out[i] = byte_in[7 - i]; // RULE_10
    end
  end
endmodule // crcbr_flip

// ==== rtl/crcbr_unit.sv ====
// crcbr_unit: byte-fed checksum unit on the special function register bus
// assumes single-cycle read and write strobes, same clock, registered read data
// Notes on behaviour
// RULE_01 - poly select 0 uses the 32-bit generator 04C11DB7, 1 uses the 16-bit generator 1021.
// RULE_02 - init value select 0 presets the result to all zeros, 1 to all ones.
// RULE_03 - writing 1 to control bit 3 presets the whole result; the bit itself is write-only.
// RULE_04 - each byte written to the input register is folded into the result at once.
// RULE_05 - the result is 32 bits wide in 32-bit mode and 16 bits wide in 16-bit mode.
// RULE_06 - the two-bit byte pointer picks the result byte and advances after each port access.
// RULE_07 - in 32-bit mode pointer 0..3 maps to result bytes 0..3.
// RULE_08 - in 16-bit mode pointers 0 and 2 map to byte 0, pointers 1 and 3 to byte 1.
// RULE_09 - the result holds until preset, port write or input byte; reads do not alter it.
// RULE_10 - a byte written to the bit reverse port reads back mirrored.
// RULE_11 - control bits 7 to 5 read as zero and ignore writes.
// RULE_12 - software selects the polynomial, then the preset, then initialises, then feeds bytes.
// RULE_13 - in 16-bit mode the byte goes into the top byte and eight msb-first shifts follow.
// RULE_14 - in 32-bit mode the byte goes into the low byte and eight reflected shifts follow.
// RULE_15 - the result and bit reverse ports are 8-bit read/write, one byte absorbed per cycle.
// RULE_16 - reset clears result, pointer and bit reverse holding register to zero.
`timescale 1ns/1ps
module crcbr_unit
  import crcbr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit
);
  import crcbr_pkg::*;

  typedef struct packed {
    logic poly_select;
    logic init_value_select;
    logic [1:0] result_byte_pointer;
    logic [31:0] result;
    logic [7:0] byte_input;
    logic [7:0] flip_hold;
    logic [7:0] rdata;
  } crcbr_state_t;

  crcbr_state_t st_reg;
  crcbr_state_t st_next;
  logic [31:0] folded;
  logic [7:0] flipped;
  logic [1:0] lane;
  logic wr_ctl;
  logic wr_in;
  logic wr_dat;
  logic rd_dat;
  logic wr_flip;

  // =====================================================================
  // helpers
  // =====================================================================
  // byte lane of the result addressed by the pointer
  function automatic logic [1:0] lane_of(input logic [1:0] ptr, input logic mode16);
    lane_of = mode16 ? {1'b0, ptr[0]} : ptr; // RULE_07 RULE_08
  endfunction

  function automatic logic [7:0] control_view(input crcbr_state_t s);
    control_view = {3'b000, s.poly_select, 1'b0, s.init_value_select, s.result_byte_pointer}; // RULE_11
  endfunction

  crcbr_fold u_fold (
    .acc_in(st_reg.result),
    .data_in(sfr_wdata),
    .poly16_mode(st_reg.poly_select),
    .acc_out(folded)
  );

  crcbr_flip u_flip (
    .byte_in(st_reg.flip_hold),
    .byte_out(flipped)
  );

  // =====================================================================
  // decode
  // =====================================================================
  assign wr_ctl = sfr_wr && (sfr_addr == ADDR_CONTROL);
  assign wr_in = sfr_wr && (sfr_addr == ADDR_BYTE_INPUT);
  assign wr_dat = sfr_wr && (sfr_addr == ADDR_RESULT_PORT);
  assign rd_dat = sfr_rd && (sfr_addr == ADDR_RESULT_PORT);
  assign wr_flip = sfr_wr && (sfr_addr == ADDR_BIT_REVERSE);
  assign lane = lane_of(st_reg.result_byte_pointer, st_reg.poly_select);
  assign sfr_hit = (sfr_addr == ADDR_CONTROL) || (sfr_addr == ADDR_BYTE_INPUT)
                   || (sfr_addr == ADDR_RESULT_PORT) || (sfr_addr == ADDR_BIT_REVERSE);
  assign sfr_rdata = st_reg.rdata;

  // =====================================================================
  // next state
  // =====================================================================
  always_comb
  begin
    st_next = st_reg;
    if (wr_ctl)
    begin
      st_next.poly_select = sfr_wdata[CTL_POLY_SELECT];
      st_next.init_value_select = sfr_wdata[CTL_INIT_VALUE];
      st_next.result_byte_pointer = sfr_wdata[CTL_PTR_HI:CTL_PTR_LO];
      if (sfr_wdata[CTL_INIT_STROBE])
      begin
        // preset uses the select value written in this same access
        st_next.result = sfr_wdata[CTL_INIT_VALUE] ? PRESET_ONES : PRESET_ZERO; // RULE_02 RULE_03
      end
    end
    if (wr_in)
    begin
      st_next.byte_input = sfr_wdata;
      st_next.result = folded; // RULE_04 RULE_15
    end
    if (wr_dat)
    begin
      st_next.result[lane * BITS_PER_BYTE +: BITS_PER_BYTE] = sfr_wdata; // RULE_09
    end
    if (wr_dat || rd_dat)
    begin
      st_next.result_byte_pointer = st_reg.result_byte_pointer + PTR_STEP; // RULE_06
    end
    if (wr_flip)
    begin
      st_next.flip_hold = sfr_wdata; // RULE_10
    end
    // read data registered; reads have no side effect on the result
    st_next.rdata = BYTE_ZERO;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        ADDR_CONTROL: st_next.rdata = control_view(st_reg); // RULE_11
        ADDR_BYTE_INPUT: st_next.rdata = st_reg.byte_input;
        ADDR_RESULT_PORT: st_next.rdata = st_reg.result[lane * BITS_PER_BYTE +: BITS_PER_BYTE]; // RULE_07 RULE_08
        ADDR_BIT_REVERSE: st_next.rdata = flipped; // RULE_10
        default: st_next.rdata = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= '0; // RULE_16
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // =====================================================================
  // reference models for the checks
  // =====================================================================
  // written unlike the fold and flip blocks so a shared slip cannot hide
  function automatic logic [7:0] mirror_byte(input logic [7:0] b);
    mirror_byte = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction

  function automatic logic [31:0] mirror_word(input logic [31:0] w);
    for (int i = 0; i < $bits(w); i++)
    begin
      mirror_word[i] = w[$bits(w) - 1 - i];
    end
  endfunction

  // msb-first form on mirrored words, so the reflected shifter is not trusted
  function automatic logic [31:0] ref_fold32(input logic [31:0] acc, input logic [7:0] data);
    logic [31:0] m;
    m = mirror_word(acc) ^ {mirror_byte(data), 24'h000000};
    for (int i = 0; i < BITS_PER_BYTE; i++)
    begin
      m = m[31] ? ((m << 1) ^ POLY32) : (m << 1);
    end
    ref_fold32 = mirror_word(m);
  endfunction

  // bit-serial form: each data bit meets the feedback tap, no byte pre-xor
  function automatic logic [15:0] ref_fold16(input logic [15:0] acc, input logic [7:0] data);
    logic [15:0] m;
    logic fb;
    m = acc;
    for (int i = 0; i < BITS_PER_BYTE; i++)
    begin
      fb = m[15] ^ data[BITS_PER_BYTE - 1 - i];
      m = {m[14:0], 1'b0} ^ (fb ? POLY16 : 16'h0000);
    end
    ref_fold16 = m;
  endfunction

  // =====================================================================
  // checks
  // =====================================================================
  AST_PRESET_ONES: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    wr_ctl && sfr_wdata[CTL_INIT_STROBE] && sfr_wdata[CTL_INIT_VALUE]
    |=> st_reg.result == PRESET_ONES)
    else $error("preset to ones missing");
  AST_PRESET_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    wr_ctl && sfr_wdata[CTL_INIT_STROBE] && !sfr_wdata[CTL_INIT_VALUE]
    |=> st_reg.result == PRESET_ZERO)
    else $error("preset to zero missing");
  AST_FOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    wr_in |=> st_reg.result == $past(folded))
    else $error("input byte not folded");
  AST_WIDTH16: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    wr_in && st_reg.poly_select |=> st_reg.result[31:16] == 16'h0000)
    else $error("16-bit result wider than 16 bits");
  AST_PTR_STEP: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    (wr_dat || rd_dat) |=> st_reg.result_byte_pointer == $past(st_reg.result_byte_pointer) + PTR_STEP)
    else $error("pointer did not advance");
  AST_READ_LANE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    rd_dat && !st_reg.poly_select
    |=> {24'h000000, sfr_rdata}
    == (($past(st_reg.result) >> {$past(st_reg.result_byte_pointer), 3'b000}) & 32'h000000FF))
    else $error("32-bit lane mismatch");
  AST_LANE16: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    rd_dat && st_reg.poly_select |=> sfr_rdata == (($past(st_reg.result_byte_pointer[0]) ? $past(st_reg.result[15:8]) : $past(st_reg.result[7:0]))))
    else $error("16-bit lane mismatch");
  AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    !wr_ctl && !wr_in && !wr_dat |=> $stable(st_reg.result))
    else $error("result changed without cause");
  AST_FLIP: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    sfr_rd && sfr_addr == ADDR_BIT_REVERSE |=> sfr_rdata == mirror_byte($past(st_reg.flip_hold)))
    else $error("bit reverse readback wrong");
  AST_CTL_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    sfr_rd && sfr_addr == ADDR_CONTROL |=> sfr_rdata[7:5] == 3'b000 && sfr_rdata[CTL_INIT_STROBE] == 1'b0)
    else $error("control reserved bits not zero");

  // =====================================================================
  // checks: control and folding
  // =====================================================================
  AST_CTL_NO_INIT: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    wr_ctl && !sfr_wdata[CTL_INIT_STROBE] |=> $stable(st_reg.result))
    else $error("control write without init changed the result");
  AST_CTL_LOAD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    wr_ctl |=> st_reg.poly_select == $past(sfr_wdata[CTL_POLY_SELECT])
    && st_reg.init_value_select == $past(sfr_wdata[CTL_INIT_VALUE]))
    else $error("control selects not loaded");
  AST_SEL_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    !wr_ctl |=> $stable(st_reg.poly_select) && $stable(st_reg.init_value_select))
    else $error("control selects changed without a write");
  AST_FOLD32_REF: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
    wr_in && !st_reg.poly_select
    |=> st_reg.result == ref_fold32($past(st_reg.result), $past(sfr_wdata)))
    else $error("32-bit fold differs from reference");
  AST_FOLD16_REF: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
    wr_in && st_reg.poly_select
    |=> st_reg.result[15:0] == ref_fold16($past(st_reg.result[15:0]), $past(sfr_wdata)))
    else $error("16-bit fold differs from reference");

  // =====================================================================
  // checks: result port and pointer
  // =====================================================================
  // reads step the pointer as well, so only a control write may reload it
  AST_PTR_LOAD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    wr_ctl && !rd_dat |=> st_reg.result_byte_pointer == $past(sfr_wdata[CTL_PTR_HI:CTL_PTR_LO]))
    else $error("pointer not loaded by control write");
  AST_PTR_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    !wr_ctl && !wr_dat && !rd_dat |=> $stable(st_reg.result_byte_pointer))
    else $error("pointer moved without an access");
  AST_PORT_WRITE32: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    wr_dat && !st_reg.poly_select
    |=> ((st_reg.result >> {$past(st_reg.result_byte_pointer), 3'b000}) & 32'h000000FF)
    == {24'h000000, $past(sfr_wdata)})
    else $error("32-bit port write landed in the wrong byte");
  AST_PORT_KEEP32: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    wr_dat && !st_reg.poly_select
    |=> (st_reg.result & ~(32'h000000FF << {$past(st_reg.result_byte_pointer), 3'b000}))
    == ($past(st_reg.result) & ~(32'h000000FF << {$past(st_reg.result_byte_pointer), 3'b000})))
    else $error("32-bit port write disturbed other bytes");
  AST_PORT_WRITE16: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    wr_dat && st_reg.poly_select
    |=> ($past(st_reg.result_byte_pointer[0]) ? st_reg.result[15:8] : st_reg.result[7:0]) == $past(sfr_wdata))
    else $error("16-bit port write landed in the wrong byte");
  AST_WIDTH16_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    wr_dat && st_reg.poly_select |=> st_reg.result[31:16] == $past(st_reg.result[31:16]))
    else $error("16-bit port write reached the upper half");
  AST_READ_NO_SIDE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    sfr_rd && !sfr_wr |=> $stable(st_reg.result))
    else $error("read altered the result");

  // =====================================================================
  // checks: read data and holding registers
  // =====================================================================
  // read data stands one cycle only, a late sampler sees zero
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    !sfr_rd |=> sfr_rdata == BYTE_ZERO)
    else $error("read data not cleared after its cycle");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    sfr_rd && !sfr_hit |=> sfr_rdata == BYTE_ZERO)
    else $error("unmapped read returned data");
  AST_CTL_READ: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    sfr_rd && sfr_addr == ADDR_CONTROL
    |=> sfr_rdata[CTL_POLY_SELECT] == $past(st_reg.poly_select)
    && sfr_rdata[CTL_INIT_VALUE] == $past(st_reg.init_value_select)
    && sfr_rdata[CTL_PTR_HI:CTL_PTR_LO] == $past(st_reg.result_byte_pointer))
    else $error("control readback wrong");
  AST_INPUT_READBACK: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    sfr_rd && sfr_addr == ADDR_BYTE_INPUT |=> sfr_rdata == $past(st_reg.byte_input))
    else $error("byte input readback wrong");
  AST_INPUT_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    !wr_in |=> $stable(st_reg.byte_input))
    else $error("byte input changed without a write");
  AST_FLIP_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    wr_flip |=> st_reg.flip_hold == $past(sfr_wdata))
    else $error("bit reverse byte not captured");
  AST_FLIP_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    !wr_flip |=> $stable(st_reg.flip_hold))
    else $error("bit reverse byte changed without a write");
endmodule // crcbr_unit

// ==== tb/crcbr_host.sv ====
// crcbr_host: processor core model driving the special function register bus
// assumes single-cycle strobes and read data valid one cycle after the read
`timescale 1ns/1ps
module crcbr_host
(
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // ==========================================
  // bus cycles
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
    sfr_addr <= ~a;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    #1 d = sfr_rdata;
  endtask
endmodule // crcbr_host

// ==== tb/crcbr_unit_tb.sv ====
// crcbr_unit_tb: self-checking bench for the checksum unit
// assumes the host model for bus cycles and a 40 MHz clock
`timescale 1ns/1ps
module crcbr_unit_tb;
  import crcbr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic sfr_wr, sfr_rd, sfr_hit;
  int n_errors = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  crcbr_host host_u (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  crcbr_unit dut_u (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));
  // ==========================================
  // comparison and closing
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // reads n result bytes through the port, pointer assumed at 0
  task automatic read_result(input logic [31:0] exp, input int n);
    for (int i = 0; i < n; i++)
    begin
      host_u.rd(ADDR_RESULT_PORT, v);
      check("result byte", exp[8*(i%4) +: 8], v);
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset_values;
    host_u.rd(ADDR_CONTROL, v);
    check("control", CONTROL_RESET, v);
    host_u.rd(ADDR_BYTE_INPUT, v);
    check("byte input", BYTE_ZERO, v);
    read_result(32'h00000000, 4);
  endtask
  task automatic t_crc16;
    host_u.wr(ADDR_CONTROL, 8'h1C);
    host_u.wr(ADDR_BYTE_INPUT, 8'h63);
    read_result(32'h0000BD35, 2);
    read_result(32'hBD35BD35, 4);
    host_u.wr(ADDR_CONTROL, 8'h1C);
    host_u.wr(ADDR_BYTE_INPUT, 8'hAA);
    host_u.wr(ADDR_BYTE_INPUT, 8'hBB);
    host_u.wr(ADDR_BYTE_INPUT, 8'hCC);
    read_result(32'h00006CF6, 2);
    // pointer at 2: the write lands in the low byte, the reads start at 3
    host_u.wr(ADDR_RESULT_PORT, 8'hA5);
    read_result(32'h0000A56C, 2);
  endtask
  task automatic t_crc32;
    host_u.wr(ADDR_CONTROL, 8'h0C);
    host_u.wr(ADDR_BYTE_INPUT, 8'h63);
    read_result(32'hF9462090, 4);
    read_result(32'hF9462090, 4);
    host_u.wr(ADDR_CONTROL, 8'h08);
    read_result(32'h00000000, 4);
    host_u.wr(ADDR_CONTROL, 8'h0E);
    host_u.wr(ADDR_RESULT_PORT, 8'h5A);
    host_u.wr(ADDR_CONTROL, 8'h00);
    read_result(32'hFFFFFFFF, 2);
    // pointer at 2, so the lanes come back as 2, 3, 0, 1
    read_result(32'hFFFFFF5A, 4);
  endtask
  task automatic t_control_and_flip;
    host_u.wr(ADDR_CONTROL, 8'hFF);
    host_u.rd(ADDR_CONTROL, v);
    check("control", 8'h17, v);
    host_u.wr(ADDR_BIT_REVERSE, 8'hC0);
    host_u.rd(ADDR_BIT_REVERSE, v);
    check("bit reverse", 8'h03, v);
    host_u.wr(ADDR_BIT_REVERSE, 8'h35);
    host_u.rd(ADDR_BIT_REVERSE, v);
    check("bit reverse", 8'hAC, v);
    host_u.rd(8'h90, v);
    check("unmapped read", 8'h00, v);
    check("hit", 8'h00, {7'h00, sfr_hit});
    fork
      host_u.rd(ADDR_CONTROL, v);
      begin
        @(posedge clk);
        #1 check("hit", 8'h01, {7'h00, sfr_hit});
      end
    join
    check("control", 8'h17, v);
  endtask
  task automatic t_second_reset;
    host_u.wr(ADDR_CONTROL, 8'h0C);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    read_result(32'h00000000, 4);
    host_u.rd(ADDR_BIT_REVERSE, v);
    check("bit reverse", 8'h00, v);
    host_u.rd(ADDR_CONTROL, v);
    check("control", CONTROL_RESET, v);
  endtask
  // ==========================================
  // main sequence and watchdog
  // about 62 bus cycles are needed, so 5000 clocks is ample
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_crc16();
    t_crc32();
    t_control_and_flip();
    t_second_reset();
    complete_run();
  end
endmodule // crcbr_unit_tb
